// >>> logic/lqa_limit_access.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Limit writes are ignored while the device is powered down.
// RULE_02: Access bits 15:14 ignore writes and read zero.
// RULE_03: Setting the sample bit captures the selected live parameter.
// RULE_04: Strobe stores data field into limit addressed by both selectors.
// RULE_05: Strobe bit never stores a one and always reads zero.
// RULE_06: Selector codes 0..4 pick C1, gain, wander, offset, control.
// RULE_07: One selector serves both sampling and limit access.
// RULE_08: High/low bit picks low (0) or high (1) limit; ten limits.
// RULE_09: With sampling off, data field is the value stored by strobe.
// RULE_10: With sampling off, data field reads the addressed limit.
// RULE_11: With sampling on, data field reads the captured parameter.
// RULE_12: Captured value stays frozen until a new sampling sequence.
// RULE_13: Monitor compares only while enabled with a 100 Mb link up.
// RULE_14: A limit at min or max value disables that comparison.
// RULE_15: Crossing a limit sets its warning flag and may interrupt.
// RULE_16: Reading monitor control clears all warning flags; the code keeps set any flag whose limit is crossed in the read cycle.
// RULE_17: Selector codes 5..7 address no limit; writes drop, reads zero.
// RULE_18: Ten 8-bit limits reset to zero with the access fields.
module lqa_limit_access
(
   // Clock and reset
   input wire logic CLOCK_IN,
   input wire logic RSTN_IN,
   // Receiver status
   input wire lqa_pkg::lqa_phy_s PHY_IN,
   // AXI4-Lite write address
   input wire logic AWVALID_IN,
   input wire logic [lqa_pkg::ADDR_W-1:0] AWADDR_IN,
   output logic AWREADY_OUT,
   // AXI4-Lite write data
   input wire logic WVALID_IN,
   input wire logic [lqa_pkg::DATA_W-1:0] WDATA_IN,
   input wire logic [3:0] WSTRB_IN,
   output logic WREADY_OUT,
   // AXI4-Lite write response
   output logic BVALID_OUT,
   output logic [lqa_pkg::RESP_W-1:0] BRESP_OUT,
   input wire logic BREADY_IN,
   // AXI4-Lite read address
   input wire logic ARVALID_IN,
   input wire logic [lqa_pkg::ADDR_W-1:0] ARADDR_IN,
   output logic ARREADY_OUT,
   // AXI4-Lite read data
   output logic RVALID_OUT,
   output logic [lqa_pkg::DATA_W-1:0] RDATA_OUT,
   output logic [lqa_pkg::RESP_W-1:0] RRESP_OUT,
   input wire logic RREADY_IN,
   // Interrupt
   output logic IRQ_OUT
);
   typedef struct packed
   {
      logic aw_have;
      logic [lqa_pkg::ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [lqa_pkg::DATA_W-1:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [lqa_pkg::RESP_W-1:0] bresp;
      logic rvalid;
      logic [lqa_pkg::DATA_W-1:0] rdata;
      logic [lqa_pkg::RESP_W-1:0] rresp;
      lqa_pkg::lqa_access_s acc;
      logic [lqa_pkg::LIM_W-1:0] captured;
      logic mon_en;
      lqa_pkg::lqa_cmp_s cmp;
      logic [lqa_pkg::NUM_WARN-1:0] int_status;
      logic [lqa_pkg::NUM_WARN-1:0] int_enable;
   } lqa_state_s;

   lqa_state_s st_r;
   lqa_state_s st_nxt;
   logic [lqa_pkg::NUM_WARN-1:0] hit;
   logic [lqa_pkg::NUM_WARN-1:0] warn_rise;
   logic [15:0] access_word;
   logic [15:0] wr_half;
   logic [3:0] lim_idx;
   logic lim_valid;
   logic do_write;
   logic do_read;

   ////////////////////////////////////////////////////////////////////////
   lqa_compare u_compare
   (
      .enable_in(st_r.mon_en),
      .phy_in(PHY_IN),
      .lim_in(st_r.cmp.lim),
      .hit_out(hit)
   );

   ////////////////////////////////////////////////////////////////////////
   assign AWREADY_OUT = !st_r.aw_have && !st_r.bvalid;
   assign WREADY_OUT = !st_r.w_have && !st_r.bvalid;
   assign ARREADY_OUT = !st_r.rvalid;
   assign BVALID_OUT = st_r.bvalid;
   assign BRESP_OUT = st_r.bresp;
   assign RVALID_OUT = st_r.rvalid;
   assign RDATA_OUT = st_r.rdata;
   assign RRESP_OUT = st_r.rresp;
   // Level output, any enabled sticky status bit
   assign IRQ_OUT = |(st_r.int_status & st_r.int_enable); //RULE_15

   assign lim_valid = st_r.acc.psel <= lqa_pkg::PSEL_MAX; //RULE_17
   assign lim_idx = {st_r.acc.psel, st_r.acc.hl}; //RULE_07 RULE_08
   assign do_write = st_r.aw_have && st_r.w_have && !st_r.bvalid;
   assign do_read = ARVALID_IN && ARREADY_OUT;
   // Only a new warning raises a status bit; a held one must not re-arm
   assign warn_rise = hit & ~st_r.cmp.warn;

   always_comb
   begin
      access_word = '0; //RULE_02 RULE_05
      access_word[lqa_pkg::SAMPLE_BIT] = st_r.acc.sample;
      access_word[lqa_pkg::PSEL_HI:lqa_pkg::PSEL_LO] = st_r.acc.psel;
      access_word[lqa_pkg::HL_BIT] = st_r.acc.hl;
      if (st_r.acc.sample)
      begin
         access_word[lqa_pkg::LDATA_HI:0] = st_r.captured; //RULE_11
      end
      else if (lim_valid)
      begin
         access_word[lqa_pkg::LDATA_HI:0] = st_r.cmp.lim[lim_idx]; //RULE_10
      end
   end

   // Only the low half-word lanes carry the 16-bit registers
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         wr_half[8*i +: 8] = st_r.w_strb[i] ? st_r.w_data[8*i +: 8] : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [3:0] widx;
      logic [15:0] nw;
      widx = '0;
      nw = '0;
      st_nxt = st_r;
      // Sticky bits: hardware set wins over the software clear below
      st_nxt.cmp.warn = st_r.cmp.warn | hit; //RULE_15
      if (AWVALID_IN && AWREADY_OUT)
      begin
         st_nxt.aw_have = 1'b1;
         st_nxt.aw_addr = AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT)
      begin
         st_nxt.w_have = 1'b1;
         st_nxt.w_data = WDATA_IN;
         st_nxt.w_strb = WSTRB_IN;
      end
      if (BVALID_OUT && BREADY_IN)
      begin
         st_nxt.bvalid = 1'b0;
      end
      if (RVALID_OUT && RREADY_IN)
      begin
         st_nxt.rvalid = 1'b0;
      end
      if (do_write)
      begin
         st_nxt.aw_have = 1'b0;
         st_nxt.w_have = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = lqa_pkg::RESP_OKAY;
         // Written lanes replace the field; a zero must be able to clear
         nw = wr_half;
         if (!st_r.w_strb[1])
         begin
            nw[15:8] = access_word[15:8];
         end
         if (!st_r.w_strb[0])
         begin
            nw[7:0] = st_r.acc.ldata;
         end
         unique case (st_r.aw_addr)
            lqa_pkg::ADDR_ACCESS:
            begin
               // Bits 15:14 and the strobe are never stored
               st_nxt.acc.sample = nw[lqa_pkg::SAMPLE_BIT];
               st_nxt.acc.psel = nw[lqa_pkg::PSEL_HI:lqa_pkg::PSEL_LO];
               st_nxt.acc.hl = nw[lqa_pkg::HL_BIT];
               st_nxt.acc.ldata = nw[lqa_pkg::LDATA_HI:0]; //RULE_09
               // Rising sample bit starts a new capture, then it freezes
               if (nw[lqa_pkg::SAMPLE_BIT] && !st_r.acc.sample)
               begin
                  st_nxt.captured =
                     PHY_IN.live[nw[lqa_pkg::PSEL_HI:lqa_pkg::PSEL_LO]]; //RULE_03 RULE_12 RULE_06
                  if (nw[lqa_pkg::PSEL_HI:lqa_pkg::PSEL_LO] >
                      lqa_pkg::PSEL_MAX)
                  begin
                     st_nxt.captured = '0;
                  end
               end
               widx = {nw[lqa_pkg::PSEL_HI:lqa_pkg::PSEL_LO],
                       nw[lqa_pkg::HL_BIT]};
               if (nw[lqa_pkg::STROBE_BIT] && !PHY_IN.powered_down //RULE_01
                   && nw[lqa_pkg::PSEL_HI:lqa_pkg::PSEL_LO] <=
                      lqa_pkg::PSEL_MAX) //RULE_17
               begin
                  st_nxt.cmp.lim[widx] = nw[lqa_pkg::LDATA_HI:0]; //RULE_04
               end
            end
            lqa_pkg::ADDR_MONITOR:
            begin
               st_nxt.mon_en = nw[lqa_pkg::MON_EN_BIT];
            end
            lqa_pkg::ADDR_INT_ENABLE:
            begin
               st_nxt.int_enable = nw[lqa_pkg::NUM_WARN-1:0];
            end
            lqa_pkg::ADDR_INT_CLEAR:
            begin
               st_nxt.int_status = st_r.int_status &
                  ~nw[lqa_pkg::NUM_WARN-1:0];
            end
            lqa_pkg::ADDR_INT_STATUS:
            begin
            end
            default:
            begin
               st_nxt.bresp = lqa_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (do_read)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = lqa_pkg::RESP_OKAY;
         st_nxt.rdata = '0;
         unique case (ARADDR_IN)
            lqa_pkg::ADDR_ACCESS:
            begin
               st_nxt.rdata[15:0] = access_word;
            end
            lqa_pkg::ADDR_MONITOR:
            begin
               st_nxt.rdata[lqa_pkg::MON_EN_BIT] = st_r.mon_en;
               st_nxt.rdata[lqa_pkg::NUM_WARN-1:0] = st_r.cmp.warn;
               // Clear on read; a crossing in this cycle stays flagged
               st_nxt.cmp.warn = hit; //RULE_16
            end
            lqa_pkg::ADDR_INT_STATUS:
            begin
               st_nxt.rdata[lqa_pkg::NUM_WARN-1:0] = st_r.int_status;
            end
            lqa_pkg::ADDR_INT_ENABLE:
            begin
               st_nxt.rdata[lqa_pkg::NUM_WARN-1:0] = st_r.int_enable;
            end
            lqa_pkg::ADDR_INT_CLEAR:
            begin
            end
            default:
            begin
               st_nxt.rresp = lqa_pkg::RESP_SLVERR;
            end
         endcase
      end
      st_nxt.int_status = st_nxt.int_status | warn_rise; //RULE_15
   end

   always_ff @(posedge CLOCK_IN)
   begin
      if (!RSTN_IN)
      begin
         st_r <= '0; //RULE_18
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic wr_acc;
   assign wr_acc = do_write && st_r.aw_addr == lqa_pkg::ADDR_ACCESS;

   property p_pd_block;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      PHY_IN.powered_down |=> $stable(st_r.cmp.lim);
   endproperty
   a_pd_block: assert property (p_pd_block) //RULE_01
      else $error("limit changed while powered down");

   property p_top_zero;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      do_read && ARADDR_IN == lqa_pkg::ADDR_ACCESS
      |=> RDATA_OUT[15:14] == 2'h0;
   endproperty
   a_top_zero: assert property (p_top_zero) //RULE_02
      else $error("reserved bits read nonzero");

   property p_strobe_zero;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      do_read && ARADDR_IN == lqa_pkg::ADDR_ACCESS
      |=> RDATA_OUT[lqa_pkg::STROBE_BIT] == 1'b0;
   endproperty
   a_strobe_zero: assert property (p_strobe_zero) //RULE_05
      else $error("strobe bit read back as one");

   property p_frozen;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      st_r.acc.sample ##1 st_r.acc.sample |-> $stable(st_r.captured);
   endproperty
   a_frozen: assert property (p_frozen) //RULE_12
      else $error("captured value moved while frozen");

   property p_sample_read;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      do_read && ARADDR_IN == lqa_pkg::ADDR_ACCESS && st_r.acc.sample
      |=> RDATA_OUT[lqa_pkg::LDATA_HI:0] == $past(st_r.captured);
   endproperty
   a_sample_read: assert property (p_sample_read) //RULE_11
      else $error("sample read did not return capture");

   property p_store;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      wr_acc && (&st_r.w_strb[1:0]) && st_r.w_data[lqa_pkg::STROBE_BIT]
      && !PHY_IN.powered_down
      && st_r.w_data[lqa_pkg::PSEL_HI:lqa_pkg::PSEL_LO] <= lqa_pkg::PSEL_MAX
      |=> st_r.cmp.lim[$past(st_r.w_data[11:8])] == $past(st_r.w_data[7:0]);
   endproperty
   a_store: assert property (p_store) //RULE_04
      else $error("limit not stored by strobe");

   property p_gate;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      !PHY_IN.link_100_up || !st_r.mon_en |-> hit == '0;
   endproperty
   a_gate: assert property (p_gate) //RULE_13
      else $error("compare active without link or enable");

   property p_irq;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      (warn_rise & st_r.int_enable) != '0 |=> ##[0:1] IRQ_OUT;
   endproperty
   a_irq: assert property (p_irq) //RULE_15
      else $error("warning did not raise interrupt");

   property p_cor;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      do_read && ARADDR_IN == lqa_pkg::ADDR_MONITOR
      |=> st_r.cmp.warn == $past(hit);
   endproperty
   a_cor: assert property (p_cor) //RULE_16
      else $error("warnings not cleared on read");

   c_write: cover property (@(posedge CLOCK_IN) wr_acc);
   c_sample: cover property (@(posedge CLOCK_IN)
      st_r.acc.sample && RVALID_OUT);
   c_irq: cover property (@(posedge CLOCK_IN) $rose(IRQ_OUT));
endmodule // lqa_limit_access

// >>> pkg/lqa_pkg.sv
package lqa_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int LIM_W = 8;
   localparam int NUM_PARAM = 5;
   localparam int NUM_LIMIT = 10;
   localparam int NUM_WARN = 10;
   localparam int RESP_W = 2;
   // Byte addresses: printed 1eh is not a multiple of four, so index*4
   localparam logic [7:0] IDX_ACCESS = 8'h1e;
   localparam logic [7:0] IDX_MONITOR = 8'h1d;
   localparam logic [7:0] IDX_INT_STATUS = 8'h20;
   localparam logic [7:0] IDX_INT_ENABLE = 8'h21;
   localparam logic [7:0] IDX_INT_CLEAR = 8'h22;
   localparam logic [ADDR_W-1:0] ADDR_ACCESS = {IDX_ACCESS[5:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MONITOR = {IDX_MONITOR[5:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_INT_STATUS =
      {IDX_INT_STATUS[5:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE =
      {IDX_INT_ENABLE[5:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_INT_CLEAR = {IDX_INT_CLEAR[5:0], 2'b00};
   // Access register fields, monitor enable bit and other constants
   localparam int SAMPLE_BIT = 13;
   localparam int STROBE_BIT = 12;
   localparam int PSEL_HI = 11;
   localparam int PSEL_LO = 9;
   localparam int HL_BIT = 8;
   localparam int LDATA_HI = 7;
   localparam int MON_EN_BIT = 15;
   localparam logic [15:0] ACCESS_RESET = 16'h0000;
   localparam logic [15:0] ACCESS_MASK = 16'h3eff;
   localparam logic [2:0] PSEL_MAX = 3'h4;
   localparam logic [LIM_W-1:0] LIM_MIN = 8'h00;
   localparam logic [LIM_W-1:0] LIM_MAX = 8'hff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed
   {
      logic [2:0] psel;
      logic hl;
      logic sample;
      logic [LIM_W-1:0] ldata;
   } lqa_access_s;

   typedef struct packed
   {
      logic [NUM_PARAM-1:0][LIM_W-1:0] live;
      logic link_100_up;
      logic powered_down;
   } lqa_phy_s;

   typedef struct packed
   {
      logic [NUM_LIMIT-1:0][LIM_W-1:0] lim;
      logic [NUM_WARN-1:0] warn;
   } lqa_cmp_s;
endpackage

// >>> logic/lqa_compare.sv
`timescale 1ns/1ps
// Combinational limit check of the live parameters against stored limits
module lqa_compare
(
   // Inputs
   input wire logic enable_in,
   input wire lqa_pkg::lqa_phy_s phy_in,
   input wire logic [lqa_pkg::NUM_LIMIT-1:0][lqa_pkg::LIM_W-1:0] lim_in,
   // Outputs
   output logic [lqa_pkg::NUM_WARN-1:0] hit_out
);
   genvar g;
   generate
      for (g = 0; g < lqa_pkg::NUM_PARAM; g++)
      begin : g_par
         // Limit at the range end can never be crossed: check is off
         assign hit_out[2*g] = enable_in && phy_in.link_100_up //RULE_13
            && lim_in[2*g] != lqa_pkg::LIM_MIN //RULE_14
            && phy_in.live[g] < lim_in[2*g];
         assign hit_out[2*g+1] = enable_in && phy_in.link_100_up //RULE_13
            && lim_in[2*g+1] != lqa_pkg::LIM_MAX //RULE_14
            && phy_in.live[g] > lim_in[2*g+1];
      end
   endgenerate
endmodule // lqa_compare

// >>> dv/lqa_limit_access_tb_top.sv
`timescale 1ns/1ps
module lqa_limit_access_tb_top;
logic clk = 1'b0;
logic rstn = 1'b0;
lqa_pkg::lqa_phy_s phy;
logic awv = 1'b0;
logic wv = 1'b0;
logic bre = 1'b0;
logic arv = 1'b0;
logic rre = 1'b0;
logic [7:0] awa = 8'h00;
logic [7:0] ara = 8'h00;
logic [31:0] wd = 32'h0;
logic [3:0] ws = 4'h0;
logic awr, wr_, bv, arr, rv, irq;
logic [1:0] br, rr;
logic [31:0] rd;
logic [7:0] lim [10];
logic [4:0][7:0] v;
logic [1:0] bq [$];
logic [33:0] rq [$];
int bad_count = 0;
int n_compared = 0;

always #10 clk = ~clk;

lqa_limit_access DUT
(
   .CLOCK_IN(clk), .RSTN_IN(rstn), .PHY_IN(phy),
   .AWVALID_IN(awv), .AWADDR_IN(awa), .AWREADY_OUT(awr),
   .WVALID_IN(wv), .WDATA_IN(wd), .WSTRB_IN(ws), .WREADY_OUT(wr_),
   .BVALID_OUT(bv), .BRESP_OUT(br), .BREADY_IN(bre),
   .ARVALID_IN(arv), .ARADDR_IN(ara), .ARREADY_OUT(arr),
   .RVALID_OUT(rv), .RDATA_OUT(rd), .RRESP_OUT(rr), .RREADY_IN(rre),
   .IRQ_OUT(irq)
);

////////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
   n_compared++;
   if (g !== e)
   begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
   end
endtask

task automatic end_sim;
   $display("compared %0d bad %0d", n_compared, bad_count);
   if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
   else
      $display("Finished with errors");
   $finish;
endtask

task automatic tmo(input int n);
   if (n >= 64)
   begin
      bad_count++;
      $display("BAD handshake exp answer got none");
      end_sim;
   end
endtask

// Results are judged where they appear, against the oldest note
always @(posedge clk)
begin
   if (bv && bre)
      chk("bresp", {32'h0, bq.pop_front()}, {32'h0, br});
   if (rv && rre)
      chk("rdata", rq.pop_front(), {rr, rd});
end

////////////////////////////////////////////////////////////////////////////
task automatic wr(input logic [7:0] a, input logic [31:0] d,
   input logic [1:0] e);
   int n;
   logic ta;
   logic tw;
   ta = 1'b0;
   tw = 1'b0;
   n = 0;
   bq.push_back(e);
   @(posedge clk);
   awv <= 1'b1;
   awa <= a;
   wv <= 1'b1;
   wd <= d;
   ws <= 4'h3;
   bre <= 1'b1;
   while ((!ta || !tw) && n < 64)
   begin
      @(posedge clk);
      n++;
      if (awr && !ta)
      begin
         ta = 1'b1;
         awv <= 1'b0;
      end
      if (wr_ && !tw)
      begin
         tw = 1'b1;
         wv <= 1'b0;
      end
   end
   tmo(n);
   n = 0;
   while (!bv && n < 64)
   begin
      @(posedge clk);
      n++;
   end
   bre <= 1'b0;
   tmo(n);
endtask

task automatic rdq(input logic [7:0] a, input logic [33:0] e);
   int n;
   n = 0;
   rq.push_back(e);
   @(posedge clk);
   arv <= 1'b1;
   ara <= a;
   rre <= 1'b1;
   do
   begin
      @(posedge clk);
      n++;
   end
   while (!arr && n < 64);
   arv <= 1'b0;
   tmo(n);
   n = 0;
   do
   begin
      @(posedge clk);
      n++;
   end
   while (!rv && n < 64);
   rre <= 1'b0;
   tmo(n);
endtask

// Top two bits are always written as ones, so readback proves they drop
task automatic ax(input logic s, st, input logic [2:0] p,
   input logic h, input logic [7:0] d);
   wr(lqa_pkg::ADDR_ACCESS, {16'h0, 2'b11, s, st, p, h, d},
      lqa_pkg::RESP_OKAY);
endtask

task automatic ar(input logic s, input logic [2:0] p, input logic h,
   input logic [7:0] d);
   rdq(lqa_pkg::ADDR_ACCESS, {2'b00, 16'h0, 2'b00, s, 1'b0, p, h, d});
endtask

////////////////////////////////////////////////////////////////////////////
initial
begin
   phy = '0;
   void'($urandom(54));
   repeat (4) @(posedge clk);
   rstn <= 1'b1;
   ar(0, 0, 0, 8'h00);
   rdq(lqa_pkg::ADDR_INT_STATUS, 34'h0);
   $display("test reset done");
   for (int i = 0; i < 10; i++)
   begin
      lim[i] = 8'($urandom);
      ax(0, 1, 3'(i / 2), 1'(i % 2), lim[i]);
   end
   // Garbage data without strobe must not disturb the stored limit
   for (int i = 0; i < 10; i++)
   begin
      ax(0, 0, 3'(i / 2), 1'(i % 2), ~lim[i]);
      ar(0, 3'(i / 2), 1'(i % 2), lim[i]);
   end
   for (int p = 5; p < 8; p++)
   begin
      ax(0, 1, 3'(p), 0, 8'h5a);
      ar(0, 3'(p), 0, 8'h00);
   end
   $display("test limits done");
   @(posedge clk);
   phy.powered_down <= 1'b1;
   ax(0, 1, 0, 0, ~lim[0]);
   ar(0, 0, 0, lim[0]);
   @(posedge clk);
   phy.powered_down <= 1'b0;
   $display("test power down done");
   for (int p = 0; p < 5; p++)
   begin
      v = {8'($urandom), 32'($urandom)};
      phy.live <= v;
      ax(0, 0, 3'(p), 0, 8'h00);
      ax(1, 0, 3'(p), 0, 8'h00);
      ar(1, 3'(p), 0, v[p]);
      phy.live <= ~v;
      ar(1, 3'(p), 0, v[p]);
   end
   ax(0, 0, 0, 0, 8'h00);
   $display("test sampling done");
   rdq(8'h00, {lqa_pkg::RESP_SLVERR, 32'h0});
   wr(8'h00, 32'h1, lqa_pkg::RESP_SLVERR);
   $display("test unmapped done");
   // Extreme limits everywhere, then one live low limit on gain
   for (int i = 0; i < 10; i++)
      ax(0, 1, 3'(i / 2), 1'(i % 2), (i % 2) ? 8'hff : 8'h00);
   ax(0, 1, 1, 0, 8'h80);
   phy.live <= {5{8'h10}};
   phy.link_100_up <= 1'b1;
   wr(lqa_pkg::ADDR_INT_ENABLE, 32'h3ff, lqa_pkg::RESP_OKAY);
   wr(lqa_pkg::ADDR_MONITOR, 32'h8000, lqa_pkg::RESP_OKAY);
   rdq(lqa_pkg::ADDR_INT_STATUS, 34'h4);
   chk("irq", 34'h1, {33'h0, irq});
   wr(lqa_pkg::ADDR_INT_ENABLE, 32'h0, lqa_pkg::RESP_OKAY);
   rdq(lqa_pkg::ADDR_INT_STATUS, 34'h4);
   chk("irq", 34'h0, {33'h0, irq});
   wr(lqa_pkg::ADDR_INT_ENABLE, 32'h3ff, lqa_pkg::RESP_OKAY);
   wr(lqa_pkg::ADDR_INT_CLEAR, 32'h4, lqa_pkg::RESP_OKAY);
   rdq(lqa_pkg::ADDR_INT_STATUS, 34'h0);
   chk("irq", 34'h0, {33'h0, irq});
   phy.live[1] <= 8'h90;
   rdq(lqa_pkg::ADDR_MONITOR, 34'h8004);
   rdq(lqa_pkg::ADDR_MONITOR, 34'h8000);
   $display("test monitor done");
   phy.link_100_up <= 1'b0;
   phy.live[1] <= 8'h10;
   rdq(lqa_pkg::ADDR_INT_STATUS, 34'h0);
   rdq(lqa_pkg::ADDR_MONITOR, 34'h8000);
   $display("test link down done");
   end_sim;
end
endmodule // lqa_limit_access_tb_top
